// ===== src/drive_link_consts.svh
`ifndef DRIVE_LINK_CONSTS_SVH
`define DRIVE_LINK_CONSTS_SVH

// ----------------------------------------------------------------------------
// Object indices
// ----------------------------------------------------------------------------
`define IDX_PROD_DATE       16'h209d
`define IDX_VERSION         16'h209e
`define IDX_NOMINAL         16'h209f
`define IDX_WATCHDOG        16'h20a0
`define IDX_GAP_TIME        16'h20a1
`define IDX_NODE_ADDR       16'h20a2
`define IDX_BIT_RATE        16'h20a3
`define IDX_ACTIVATION      16'h20a4
`define IDX_TEMPERATURE     16'h20a5

// ----------------------------------------------------------------------------
// Value ranges and reset values
// ----------------------------------------------------------------------------
`define NOMINAL_COUNT       8'h04
`define NOMINAL_LAST_SUB    8'h04
`define WATCHDOG_RESET      16'h0014
`define WATCHDOG_MIN        16'h0001
`define WATCHDOG_MAX        16'h0064
`define WATCHDOG_OFF        16'h00ff
`define NODE_ADDR_RESET     8'h01
`define NODE_ADDR_ACTIVATE  8'h01
`define NODE_ADDR_MAX       8'hfd
`define RATE_9600           32'h00002580
`define RATE_19200          32'h00004b00
`define RATE_38400          32'h00009600
`define RATE_RESET          32'h00009600
`define ACTIVATION_RESET    8'h00
`define ACTIVATION_MAX      8'h01

// Gap time in ms that matches each bit rate
`define GAP_9600            16'h0004
`define GAP_19200           16'h0002
`define GAP_38400           16'h0001

// ----------------------------------------------------------------------------
// Control word bit positions
// ----------------------------------------------------------------------------
`define CTRL_SWITCH_ON      0
`define CTRL_FAULT_ACK      7
`define CTRL_READY          10

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS       25
`define MS_TIME_NS          1000000
`define TENTH_SEC_TIME_NS   100000000

`endif

// ===== src/drive_link_pkg.sv
package drive_link_pkg;

  // Drive state as seen by the communication watchdog
  typedef enum logic [3:0] {
    ST_IDLE      = 4'h1,
    ST_SWITCH_ON = 4'h2,
    ST_OPERATION = 4'h4,
    ST_FAULT     = 4'h8
  } drive_state_t;

  typedef logic [31:0]      text4_t;
  typedef logic [55:0]      text7_t;
  typedef logic [3:0][31:0] nominal_text_t;

endpackage : drive_link_pkg

// ===== src/tick_if.sv
`timescale 1ns/1ps
// Shared time base between the divider and the idle timers
interface tick_if;
  logic ms_tick;     // One-cycle pulse every millisecond
  logic tenth_tick;  // One-cycle pulse every tenth of a second

  modport source (output ms_tick, output tenth_tick);
  modport sink   (input ms_tick, input tenth_tick);
endinterface : tick_if

// ===== src/tick_gen.sv
`timescale 1ns/1ps
module tick_gen #(
  parameter int unsigned MS_CYCLES    = 40000,
  parameter int unsigned TENTH_CYCLES = 4000000
) (
  input  wire logic clock_i,    // System clock
  input  wire logic reset_n_i,  // Synchronous reset, active low
  tick_if.source    ticks       // Time base out
);
  logic [31:0] ms_count;
  logic [31:0] tenth_count;

  // Millisecond divider
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      ms_count      <= 32'h0;
      ticks.ms_tick <= 1'b0;
    end else if (ms_count == 32'(MS_CYCLES - 1)) begin
      ms_count      <= 32'h0;
      ticks.ms_tick <= 1'b1;
    end else begin
      ms_count      <= ms_count + 32'h1;
      ticks.ms_tick <= 1'b0;
    end
  end

  // Tenth-second divider, free running so both timers share one phase
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      tenth_count      <= 32'h0;
      ticks.tenth_tick <= 1'b0;
    end else if (tenth_count == 32'(TENTH_CYCLES - 1)) begin
      tenth_count      <= 32'h0;
      ticks.tenth_tick <= 1'b1;
    end else begin
      tenth_count      <= tenth_count + 32'h1;
      ticks.tenth_tick <= 1'b0;
    end
  end
endmodule : tick_gen

// ===== src/idle_timer.sv
`timescale 1ns/1ps
module idle_timer #(
  parameter bit USE_TENTH = 1'b0
) (
  input  wire logic        clock_i,    // System clock
  input  wire logic        reset_n_i,  // Synchronous reset, active low
  tick_if.sink             ticks,      // Time base in
  input  wire logic        enable_i,   // Timer armed
  input  wire logic        restart_i,  // Activity seen, start over
  input  wire logic [15:0] limit_i,    // Idle limit in ticks
  output logic             expired_o   // One-cycle pulse on expiry
);
  logic [15:0] count;
  logic        tick;
  logic        fired;
  logic [15:0] limit;

  assign tick  = USE_TENTH ? ticks.tenth_tick : ticks.ms_tick;
  // A zero limit would also expire on the first tick; treat it as one tick
  assign limit = (limit_i == 16'h0) ? 16'h1 : limit_i;

  // Count ticks of silence; fire once per idle period, then wait for activity
  always_ff @(posedge clock_i) begin
    if (!reset_n_i || !enable_i || restart_i) begin
      count     <= 16'h0;
      fired     <= 1'b0;
      expired_o <= 1'b0;
    end else if (tick && !fired) begin
      if (count + 16'h1 >= limit) begin
        fired     <= 1'b1;
        expired_o <= 1'b1;
      end else begin
        expired_o <= 1'b0;
      end
      count <= count + 16'h1;
    end else begin
      expired_o <= 1'b0;
    end
  end
endmodule : idle_timer

// ===== src/drive_link_objects.sv
`timescale 1ns/1ps
`include "drive_link_consts.svh"

// How it works
// - Silent link in operation state raises fault
// - Stop a running drive on timeout
// - Timeout in tenths; 255 disables; default 20
// - Byte gap ends a received message
// - Gap time reloaded at power-up and activation
// - Written gap time waits for reset; here it never reaches the link, which takes the rate's gap
// - Written address waits for reset; here it never reaches the link, which keeps address one
// - Activation forces serial address to one
// - Bit rate only 9600, 19200, 38400
// - Rate write also sends matching gap
// - New rate effective after reset or activation; here reset loads 38400 and activation the saved rate
// - Note rate change, store it on save
// - Inactive drive ignores commands, freezes values
// - Active drive runs commands, refreshes values
// - Activation loads saved rate then resets
// - Nominal data: four text sub-entries
// - Temperature is read-only eight bits
// - Production date text read-only WW/YYYY
// - Firmware version text read-only x.xx
// - Control bit 0 in switch-on enters operation
module drive_link_objects
  import drive_link_pkg::*;
#(
  parameter int unsigned MS_CYCLES    = `MS_TIME_NS / `CLK_PERIOD_NS,
  parameter int unsigned TENTH_CYCLES = `TENTH_SEC_TIME_NS / `CLK_PERIOD_NS
) (
  input  wire logic          clock_i,          // System clock, 40 MHz
  input  wire logic          reset_n_i,        // Synchronous reset, active low
  input  wire logic          obj_wr_i,         // Object write request
  input  wire logic          obj_rd_i,         // Object read request
  input  wire logic [15:0]   obj_index_i,      // Object index
  input  wire logic [7:0]    obj_sub_i,        // Object sub-index
  input  wire logic [31:0]   obj_wdata_i,      // Write value
  output logic               obj_ack_o,        // Access done pulse
  output logic               obj_err_o,        // Access refused, with ack
  output logic [63:0]        obj_rdata_o,      // Read value, text left aligned
  input  wire logic [15:0]   ctrl_word_i,      // Control word from master
  input  wire logic          run_cmd_i,        // Run command from master
  input  wire logic          save_i,           // Save request pulse
  input  wire logic          telegram_i,       // Telegram received pulse
  input  wire logic          byte_rx_i,        // Serial byte received pulse
  input  wire logic          moving_i,         // Drive is moving
  input  wire logic [7:0]    temperature_i,    // Drive temperature, deg C
  input  text7_t             prod_date_i,      // Date text WW/YYYY
  input  text4_t             version_i,        // Version text x.xx
  input  nominal_text_t      nominal_i,        // Nominal data texts
  output logic               run_cmd_o,        // Gated run command
  output logic               refresh_o,        // Actual values refresh enable
  output logic               drive_reset_o,    // Drive reset pulse
  output logic               param_send_o,     // Rate and gap sent pulse
  output logic [31:0]        param_rate_o,     // Rate sent to drive
  output logic [15:0]        param_gap_o,      // Gap sent to drive
  output logic [31:0]        link_rate_o,      // Bit rate in effect
  output logic [15:0]        link_gap_o,       // Gap time in effect, ms
  output logic [7:0]         link_address_o,   // Address in effect
  output logic               msg_done_o,       // Message complete pulse
  output logic               ready_op_o,       // Ready for operation
  output logic               fault_o,          // Fault state
  output logic               stop_o,           // Stop movement pulse
  output logic               rate_changed_o    // Unsaved rate change
);

  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  logic [15:0]  watchdog_time;
  logic [15:0]  gap_time;
  logic [7:0]   node_address;
  logic [31:0]  bit_rate;
  logic [31:0]  saved_rate;
  logic [7:0]   activation;
  drive_state_t state;
  logic [15:0]  ctrl_prev;
  logic         activate;
  logic         wd_expired;
  logic         gap_expired;
  logic         wr_ok;
  logic         wr_hit;

  // Gap time that suits a bit rate
  function automatic logic [15:0] gap_for_rate(input logic [31:0] rate);
    if (rate == `RATE_9600) begin
      return `GAP_9600;
    end else if (rate == `RATE_19200) begin
      return `GAP_19200;
    end else begin
      return `GAP_38400;
    end
  endfunction : gap_for_rate

  // --------------------------------------------------------------------------
  // Write decode and range checks
  // --------------------------------------------------------------------------
  // A write is only stored when the value is in range, so a bad write
  // leaves the old value in place and is answered with an error
  always_comb begin
    wr_hit = 1'b1;
    wr_ok  = 1'b0;
    if (obj_index_i == `IDX_WATCHDOG) begin
      wr_ok = (obj_wdata_i[15:0] >= `WATCHDOG_MIN && obj_wdata_i[15:0] <= `WATCHDOG_MAX)
              || obj_wdata_i[15:0] == `WATCHDOG_OFF;
      wr_ok = wr_ok && obj_wdata_i[31:16] == 16'h0;
    end else if (obj_index_i == `IDX_GAP_TIME) begin
      wr_ok = obj_wdata_i[31:16] == 16'h0;
    end else if (obj_index_i == `IDX_NODE_ADDR) begin
      wr_ok = obj_wdata_i <= {24'h0, `NODE_ADDR_MAX};
    end else if (obj_index_i == `IDX_BIT_RATE) begin
      wr_ok = obj_wdata_i == `RATE_9600 || obj_wdata_i == `RATE_19200
              || obj_wdata_i == `RATE_38400;
    end else if (obj_index_i == `IDX_ACTIVATION) begin
      wr_ok = obj_wdata_i <= {24'h0, `ACTIVATION_MAX};
    end else begin
      wr_hit = 1'b0;
    end
  end

  assign activate = obj_wr_i && wr_ok && obj_index_i == `IDX_ACTIVATION
                    && activation == 8'h0 && obj_wdata_i[0];

  // --------------------------------------------------------------------------
  // Object registers
  // --------------------------------------------------------------------------
  // Watchdog time
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      watchdog_time <= `WATCHDOG_RESET;
    end else if (obj_wr_i && wr_ok && obj_index_i == `IDX_WATCHDOG) begin
      watchdog_time <= obj_wdata_i[15:0];
    end
  end

  // Gap time: written freely, overwritten with the rate's value at
  // power-up, activation and on every rate write
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      gap_time <= gap_for_rate(`RATE_RESET);
    end else if (activate) begin
      gap_time <= gap_for_rate(saved_rate);
    end else if (obj_wr_i && wr_ok && obj_index_i == `IDX_BIT_RATE) begin
      gap_time <= gap_for_rate(obj_wdata_i);
    end else if (obj_wr_i && wr_ok && obj_index_i == `IDX_GAP_TIME) begin
      gap_time <= obj_wdata_i[15:0];
    end
  end

  // Node address
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      node_address <= `NODE_ADDR_RESET;
    end else if (activate) begin
      node_address <= `NODE_ADDR_ACTIVATE;
    end else if (obj_wr_i && wr_ok && obj_index_i == `IDX_NODE_ADDR) begin
      node_address <= obj_wdata_i[7:0];
    end
  end

  // Bit rate and activation
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      bit_rate   <= `RATE_RESET;
      activation <= `ACTIVATION_RESET;
    end else if (obj_wr_i && wr_ok) begin
      if (obj_index_i == `IDX_BIT_RATE) begin
        bit_rate <= obj_wdata_i;
      end
      if (obj_index_i == `IDX_ACTIVATION) begin
        activation <= obj_wdata_i[7:0];
      end
    end
  end

  // Saved rate. There is no real nonvolatile cell here, so the copy
  // returns to the delivery rate on reset. A change arriving with the
  // save keeps the flag set, so no change is ever lost.
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      saved_rate     <= `RATE_RESET;
      rate_changed_o <= 1'b0;
    end else begin
      if (save_i && rate_changed_o) begin
        saved_rate <= bit_rate;
      end
      if (obj_wr_i && wr_ok && obj_index_i == `IDX_BIT_RATE) begin
        rate_changed_o <= 1'b1;
      end else if (save_i) begin
        rate_changed_o <= 1'b0;
      end
    end
  end

  // Rate and matching gap go out together on every accepted rate write
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      param_send_o <= 1'b0;
      param_rate_o <= `RATE_RESET;
      param_gap_o  <= gap_for_rate(`RATE_RESET);
    end else if (obj_wr_i && wr_ok && obj_index_i == `IDX_BIT_RATE) begin
      param_send_o <= 1'b1;
      param_rate_o <= obj_wdata_i;
      param_gap_o  <= gap_for_rate(obj_wdata_i);
    end else begin
      param_send_o <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Settings in effect on the link
  // --------------------------------------------------------------------------
  // Reset loads the delivery settings and written address and gap never reach the link;
  // activation loads the saved rate, its gap and address one, then resets the drive
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      link_rate_o    <= `RATE_RESET;
      link_gap_o     <= gap_for_rate(`RATE_RESET);
      link_address_o <= `NODE_ADDR_RESET;
      drive_reset_o  <= 1'b0;
    end else if (activate) begin
      link_rate_o    <= saved_rate;
      link_gap_o     <= gap_for_rate(saved_rate);
      link_address_o <= `NODE_ADDR_ACTIVATE;
      drive_reset_o  <= 1'b1;
    end else begin
      drive_reset_o  <= 1'b0;
    end
  end

  // Command gating and refresh enable follow the activation object
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      run_cmd_o <= 1'b0;
      refresh_o <= 1'b0;
    end else begin
      run_cmd_o <= run_cmd_i && activation[0];
      refresh_o <= activation[0];
    end
  end

  // --------------------------------------------------------------------------
  // Drive state
  // --------------------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      ctrl_prev <= 16'h0;
    end else begin
      ctrl_prev <= ctrl_word_i;
    end
  end

  // Fault leaves only on a falling acknowledge bit
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (ctrl_word_i[`CTRL_READY]) begin
            state <= ST_SWITCH_ON;
          end
        end
        ST_SWITCH_ON: begin
          if (!ctrl_word_i[`CTRL_READY]) begin
            state <= ST_IDLE;
          end else if (ctrl_word_i[`CTRL_SWITCH_ON]) begin
            state <= ST_OPERATION;
          end
        end
        ST_OPERATION: begin
          if (wd_expired) begin
            state <= ST_FAULT;
          end else if (!ctrl_word_i[`CTRL_READY]) begin
            state <= ST_IDLE;
          end else if (!ctrl_word_i[`CTRL_SWITCH_ON]) begin
            state <= ST_SWITCH_ON;
          end
        end
        ST_FAULT: begin
          if (ctrl_prev[`CTRL_FAULT_ACK] && !ctrl_word_i[`CTRL_FAULT_ACK]) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // State flags and stop request
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      ready_op_o <= 1'b0;
      fault_o    <= 1'b0;
      stop_o     <= 1'b0;
    end else begin
      ready_op_o <= state == ST_OPERATION && !wd_expired;
      fault_o    <= state == ST_FAULT || (state == ST_OPERATION && wd_expired);
      stop_o     <= state == ST_OPERATION && wd_expired && moving_i;
    end
  end

  // Message complete marker
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      msg_done_o <= 1'b0;
    end else begin
      msg_done_o <= gap_expired;
    end
  end

  // --------------------------------------------------------------------------
  // Timers
  // --------------------------------------------------------------------------
  tick_if ticks ();

  tick_gen #(
    .MS_CYCLES    (MS_CYCLES),
    .TENTH_CYCLES (TENTH_CYCLES)
  ) u_tick_gen (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .ticks     (ticks)
  );

  // Watchdog only runs in the operation state and when not switched off
  idle_timer #(
    .USE_TENTH (1'b1)
  ) u_watchdog (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .ticks     (ticks),
    .enable_i  (state == ST_OPERATION && watchdog_time != `WATCHDOG_OFF),
    .restart_i (telegram_i),
    .limit_i   (watchdog_time),
    .expired_o (wd_expired)
  );

  // Gap timer is armed by the first byte and cleared by each further one;
  // tick phase makes the actual gap up to one millisecond short
  logic in_message;

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      in_message <= 1'b0;
    end else if (byte_rx_i) begin
      in_message <= 1'b1;
    end else if (gap_expired) begin
      in_message <= 1'b0;
    end
  end

  idle_timer #(
    .USE_TENTH (1'b0)
  ) u_gap_timer (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .ticks     (ticks),
    .enable_i  (in_message),
    .restart_i (byte_rx_i),
    .limit_i   (link_gap_o),
    .expired_o (gap_expired)
  );

  // --------------------------------------------------------------------------
  // Access answers
  // --------------------------------------------------------------------------
  // One cycle after the request; read-only objects refuse writes
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      obj_ack_o   <= 1'b0;
      obj_err_o   <= 1'b0;
      obj_rdata_o <= 64'h0;
    end else if (obj_wr_i) begin
      obj_ack_o <= 1'b1;
      obj_err_o <= !(wr_hit && wr_ok);
    end else if (obj_rd_i) begin
      obj_ack_o   <= 1'b1;
      obj_err_o   <= 1'b0;
      obj_rdata_o <= 64'h0;
      if (obj_index_i == `IDX_PROD_DATE) begin
        obj_rdata_o <= {prod_date_i, 8'h0};
      end else if (obj_index_i == `IDX_VERSION) begin
        obj_rdata_o <= {version_i, 32'h0};
      end else if (obj_index_i == `IDX_NOMINAL) begin
        if (obj_sub_i == 8'h0) begin
          obj_rdata_o <= {56'h0, `NOMINAL_COUNT};
        end else if (obj_sub_i <= `NOMINAL_LAST_SUB) begin
          obj_rdata_o <= {nominal_i[2'(obj_sub_i - 8'h1)], 32'h0};
        end else begin
          obj_err_o <= 1'b1;
        end
      end else if (obj_index_i == `IDX_WATCHDOG) begin
        obj_rdata_o <= {48'h0, watchdog_time};
      end else if (obj_index_i == `IDX_GAP_TIME) begin
        obj_rdata_o <= {48'h0, gap_time};
      end else if (obj_index_i == `IDX_NODE_ADDR) begin
        obj_rdata_o <= {56'h0, node_address};
      end else if (obj_index_i == `IDX_BIT_RATE) begin
        obj_rdata_o <= {32'h0, bit_rate};
      end else if (obj_index_i == `IDX_ACTIVATION) begin
        obj_rdata_o <= {56'h0, activation};
      end else if (obj_index_i == `IDX_TEMPERATURE) begin
        obj_rdata_o <= {56'h0, temperature_i};
      end else begin
        obj_err_o <= 1'b1;
      end
    end else begin
      obj_ack_o <= 1'b0;
      obj_err_o <= 1'b0;
    end
  end

endmodule : drive_link_objects

// ===== bench/drive_link_chk.sv
`timescale 1ns/1ps
module drive_link_chk (
  input wire logic        clock_i,        // Clock
  input wire logic        reset_n_i,      // Reset
  input wire logic        run_cmd_o,      // Gated run
  input wire logic        refresh_o,      // Refresh
  input wire logic        drive_reset_o,  // Drive reset
  input wire logic        param_send_o,   // Send pulse
  input wire logic [31:0] param_rate_o,   // Sent rate
  input wire logic [15:0] param_gap_o,    // Sent gap
  input wire logic [31:0] link_rate_o,    // Rate used
  input wire logic [7:0]  link_address_o, // Address used
  input wire logic        fault_o,        // Fault
  input wire logic        ready_op_o,     // Ready
  input wire logic        stop_o          // Stop
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  // Settings may only move together with a drive reset
  addr_hold_a: assert property (
    $changed(link_address_o) |-> drive_reset_o) else $error("address moved alone");
  rate_hold_a: assert property (
    $changed(link_rate_o) |-> drive_reset_o) else $error("rate moved alone");
  addr_force_a: assert property (
    drive_reset_o |-> link_address_o == 8'h01) else $error("address not one");
  act_order_a: assert property (
    $rose(refresh_o) |-> $past(drive_reset_o)) else $error("no reset first");
  run_gate_a: assert property (
    run_cmd_o |-> refresh_o) else $error("run while inactive");
  // Gap travels with its rate, never a stale pair
  gap_pair_a: assert property (
    param_send_o |-> (param_rate_o == 32'h2580 && param_gap_o == 16'h4)
    || (param_rate_o == 32'h4b00 && param_gap_o == 16'h2)
    || (param_rate_o == 32'h9600 && param_gap_o == 16'h1)) else $error("gap mismatch");
  stop_fault_a: assert property (
    stop_o |-> $rose(fault_o)) else $error("stop outside fault");
  fault_ready_a: assert property (
    $rose(fault_o) |-> !ready_op_o) else $error("ready in fault");
endmodule : drive_link_chk

bind drive_link_objects drive_link_chk drive_link_chk_inst (.*);

// ===== bench/sdo_master.sv
`timescale 1ns/1ps
module sdo_master (
  input  wire logic        clock_i, // Clock
  input  wire logic        ack_i,   // Done
  input  wire logic        err_i,   // Refused
  input  wire logic [63:0] rdata_i, // Read value
  output logic             wr_o,    // Write
  output logic             rd_o,    // Read
  output logic [15:0]      index_o, // Index
  output logic [31:0]      wdata_o  // Data
);
  initial {wr_o, rd_o, index_o, wdata_o} = '0;
  // One access; lines wander once released so stale values never pass
  task automatic xfer(input logic w, input logic [15:0] i, input logic [31:0] d,
                      output logic e, output logic [63:0] q);
    @(posedge clock_i);
    {wr_o, rd_o, index_o, wdata_o} <= {w, !w, i, d};
    @(posedge clock_i);
    {wr_o, rd_o, index_o, wdata_o} <= {2'b00, ~i, ~d};
    #1;
    e = (ack_i === 1'b1) ? err_i : 1'bx; // Missing answer fails any compare
    q = rdata_i;
  endtask : xfer
endmodule : sdo_master

// ===== bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import drive_link_pkg::*;
  logic clock_i = 0, reset_n_i = 0, save_i = 0, run_cmd_i = 0, byte_rx_i = 0;
  logic moving_i = 0, telegram_i = 0, obj_wr_i, obj_rd_i, e, s;
  logic obj_ack_o, obj_err_o, run_cmd_o, refresh_o, drive_reset_o, param_send_o;
  logic msg_done_o, ready_op_o, fault_o, stop_o, rate_changed_o;
  logic [15:0] obj_index_i, ctrl_word_i = 16'h0, param_gap_o, link_gap_o;
  logic [7:0] obj_sub_i = 8'h0, temperature_i = 8'h2d, link_address_o;
  logic [31:0] obj_wdata_i, param_rate_o, link_rate_o;
  logic [63:0] obj_rdata_o, q;
  text7_t prod_date_i = "12/2031";
  text4_t version_i = "1.05";
  nominal_text_t nominal_i = {"1500", "A025", "A120", "0024"};
  int mismatches = 0, tests_run = 0, i;
  drive_link_objects #(.MS_CYCLES(4), .TENTH_CYCLES(20)) drive_link_objects_inst (.*);
  sdo_master sdo_master_inst (.clock_i, .ack_i(obj_ack_o), .err_i(obj_err_o),
    .rdata_i(obj_rdata_o), .wr_o(obj_wr_i), .rd_o(obj_rd_i), .index_o(obj_index_i),
    .wdata_o(obj_wdata_i));
  initial forever #12.5 clock_i = ~clock_i;
  // Short counts keep the whole run far below this limit
  initial begin
    #200us;
    mismatches++;
    tally_and_finish;
  end
  task automatic chk(input string n, input logic [63:0] v, x);
    tests_run++;
    if (v !== x) begin
      mismatches++;
      $display("ERROR %s exp %h seen %h", n, x, v);
    end
  endtask : chk
  task automatic w(input logic [15:0] ix, input logic [31:0] d);
    sdo_master_inst.xfer(1'b1, ix, d, e, q);
  endtask : w
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : tick
  task automatic t_defaults;
    logic [15:0] ix [5] = '{16'h20a0, 16'h20a1, 16'h20a2, 16'h20a3, 16'h20a4};
    logic [31:0] ex [5] = '{32'h14, 32'h1, 32'h1, 32'h9600, 32'h0};
    for (int k = 0; k < 5; k++) begin
      sdo_master_inst.xfer(1'b0, ix[k], 32'h0, e, q);
      chk("reset value", q, {32'h0, ex[k]});
    end
    sdo_master_inst.xfer(1'b0, 16'h20a5, 32'h0, e, q);
    chk("temperature", q, 64'h2d);
    sdo_master_inst.xfer(1'b0, 16'h209d, 32'h0, e, q);
    chk("date", q, {"12/2031", 8'h0});
    sdo_master_inst.xfer(1'b0, 16'h209e, 32'h0, e, q);
    chk("version", q, {"1.05", 32'h0});
    @(posedge clock_i) obj_sub_i <= 8'h2;
    sdo_master_inst.xfer(1'b0, 16'h209f, 32'h0, e, q);
    chk("current", q, {"A120", 32'h0});
    w(16'h20a5, 32'h1);
    chk("temp write", e, 1);
  endtask : t_defaults
  task automatic t_rate;
    w(16'h20a3, 32'h1234);
    chk("odd rate", e, 1);
    w(16'h20a3, 32'h2580);
    chk("gap 9600", param_gap_o, 4);
    w(16'h20a3, 32'h9600);
    chk("gap 38400", param_gap_o, 1);
    w(16'h20a3, 32'h4b00);
    chk("gap 19200", param_gap_o, 2);
    chk("rate waits", link_rate_o, 32'h9600);
    @(posedge clock_i) save_i <= 1;
    @(posedge clock_i) save_i <= 0;
    #1 chk("saved", rate_changed_o, 0);
    w(16'h20a3, 32'h2580);
    chk("unsaved", rate_changed_o, 1);
  endtask : t_rate
  task automatic t_addr;
    w(16'h20a2, 32'h5);
    w(16'h20a2, 32'hfe);
    chk("addr 254", e, 1);
    sdo_master_inst.xfer(1'b0, 16'h20a2, 32'h0, e, q);
    chk("addr kept", q, 5);
    chk("addr waits", link_address_o, 1);
    w(16'h20a1, 32'h9);
    chk("gap waits", link_gap_o, 1);
  endtask : t_addr
  task automatic t_activate;
    @(posedge clock_i) run_cmd_i <= 1;
    tick(2);
    chk("run idle", run_cmd_o, 0);
    chk("frozen", refresh_o, 0);
    w(16'h20a4, 32'h1);
    chk("drive reset", drive_reset_o, 1);
    chk("saved rate", link_rate_o, 32'h4b00);
    chk("gap reload", link_gap_o, 2);
    chk("addr one", link_address_o, 1);
    tick(1);
    chk("run active", run_cmd_o, 1);
    chk("refresh", refresh_o, 1);
  endtask : t_activate
  task automatic t_gap;
    @(posedge clock_i) byte_rx_i <= 1;
    @(posedge clock_i) byte_rx_i <= 0;
    for (i = 0; i < 30 && msg_done_o !== 1'b1; i++) tick(1);
    chk("gap end", i >= 3 && i <= 11, 1);
  endtask : t_gap
  task automatic t_watchdog;
    w(16'h20a0, 32'h3);
    @(posedge clock_i) {ctrl_word_i, moving_i} <= {16'h0400, 1'b1};
    @(posedge clock_i) ctrl_word_i <= 16'h0401;
    tick(2);
    chk("ready", ready_op_o, 1);
    repeat (9) begin
      @(posedge clock_i) telegram_i <= 1;
      @(posedge clock_i) telegram_i <= 0;
      tick(10);
    end
    chk("fed", fault_o, 0);
    for (i = 0, s = 0; i < 80 && fault_o !== 1'b1; i++, s |= stop_o) tick(1);
    chk("fault", fault_o, 1);
    chk("stopped", s | stop_o, 1);
    w(16'h20a0, 32'hff);
    @(posedge clock_i) ctrl_word_i <= 16'h0481;
    @(posedge clock_i) ctrl_word_i <= 16'h0401;
    tick(90);
    chk("monitor off", fault_o, 0);
    chk("op again", ready_op_o, 1);
  endtask : t_watchdog
  task automatic tally_and_finish;
    if (mismatches == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (16) @(posedge clock_i);
    reset_n_i <= 1;
    t_defaults;
    t_rate;
    t_addr;
    t_activate;
    t_gap;
    t_watchdog;
    tally_and_finish;
  end
endmodule : tb_top
